// file: hw/pie_map.svh
// register offsets, field positions, reset values of the enable bank
`ifndef PIE_MAP_SVH
`define PIE_MAP_SVH
// byte offsets on the register bus
`define PIE_OFS_EN_A 6'h00
`define PIE_OFS_EN_B 6'h04
`define PIE_OFS_EN_C 6'h08
`define PIE_OFS_CTRL 6'h0c
`define PIE_OFS_STAT 6'h10
`define PIE_OFS_MASK 6'h14
// reset values
`define PIE_EN_RESET 8'h00
`define PIE_CTRL_RESET 2'h0
`define PIE_ST_RESET 3'h0
// control bits
`define PIE_CTRL_GLOBAL_BIT 0
`define PIE_CTRL_PRIO_BIT 1
// second enable register: unimplemented and large-package-only bits
`define PIE_B_UNIMPL_BIT 5
`define PIE_B_CMP_BIT 6
`define PIE_B_ECC_BIT 0
// can enable bits with mode dependent meaning
`define PIE_C_TXB1_BIT 3
`define PIE_C_TXB0_BIT 2
`define PIE_C_RXB0_BIT 0
// status bits: rising edge of each request line
`define PIE_ST_PERIPH_BIT 0
`define PIE_ST_HIGH_BIT 1
`define PIE_ST_LOW_BIT 2
`define PIE_ST_WIDTH 3
`endif

// file: hw/pie_pkg.sv
// types shared by the enable bank
package pie_pkg;
    // can controller operating mode
    typedef enum logic [1:0] {
        PIE_CAN_MODE0 = 2'h0,
        PIE_CAN_MODE1 = 2'h1,
        PIE_CAN_MODE2 = 2'h2
    } pie_can_mode_type;
    // bus slave states, one-hot
    typedef enum logic [1:0] {
        PIE_IDLE = 2'b01,
        PIE_ACK = 2'b10
    } pie_bus_state_type;
endpackage

// file: hw/pie_enable_reg.sv
// one software-written register with a mask of implemented bits
`timescale 1ns/1ns
module pie_enable_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] IMPL = '1,
    parameter logic [WIDTH-1:0] RESET = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write side
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    // stored value
    output logic [WIDTH-1:0] value
);
    // unimplemented bits never store a one, so they read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            value <= RESET & IMPL;
        end else if (wr_en) begin
            value <= wr_data & IMPL;
        end
    end
endmodule

// file: hw/pie_status.sv
// sticky event bits, cleared by a read, set winning over clear
`timescale 1ns/1ns
module pie_status #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // one-cycle event pulses
    input wire logic [WIDTH-1:0] set,
    // read strobe of the status register
    input wire logic clr,
    // sticky bits
    output logic [WIDTH-1:0] status
);
    // next value: clear first, then any new event on top
    logic [WIDTH-1:0] next_status;
    assign next_status = (clr ? '0 : status) | set;

    always_ff @(posedge clk) begin
        if (rst) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end
endmodule

// file: hw/pie_bank.sv
// peripheral interrupt enable bank with avalon-mm register access
`timescale 1ns/1ns
`include "pie_map.svh"
module pie_bank #(
    // one for the larger package, zero for the smaller one
    parameter bit LARGE_PACKAGE = 1'b1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // avalon-mm slave
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // peripheral flag sources
    input wire logic [7:0] FLAGS_A,
    input wire logic [7:0] FLAGS_B,
    input wire logic [7:0] FLAGS_C,
    // per-source priority bits, one means high
    input wire logic [7:0] PRIO_A,
    input wire logic [7:0] PRIO_B,
    input wire logic [7:0] PRIO_C,
    // operating mode of the can controller
    input wire pie_pkg::pie_can_mode_type CAN_MODE,
    // requests toward the core
    output logic PERIPH_REQ,
    output logic HIGH_REQ,
    output logic LOW_REQ,
    // interrupt of the bank itself
    output logic IRQ
);
    import pie_pkg::*;

    // =========================================================
    // bus slave
    // =========================================================
    // state of the slave
    pie_bus_state_type state;
    // next state
    pie_bus_state_type next_state;
    // a request is pending on the bus
    logic req;
    // request accepted at this edge
    logic take;
    // low byte lane enabled
    logic lane0;
    // write strobes per register
    logic wr_a;
    logic wr_b;
    logic wr_c;
    logic wr_ctrl;
    logic wr_mask;
    // read of the status register, clears it
    logic rd_stat;
    // read data mux
    logic [31:0] rd_mux;

    assign req = AVS_READ | AVS_WRITE;
    // first edge of a request: answer prepared, waitrequest dropped
    assign take = req && (state == PIE_IDLE);
    assign lane0 = AVS_BYTEENABLE[0];
    // writes land at the edge where waitrequest is seen low
    assign wr_a = AVS_WRITE && (state == PIE_ACK) && lane0 && (AVS_ADDRESS == `PIE_OFS_EN_A);
    assign wr_b = AVS_WRITE && (state == PIE_ACK) && lane0 && (AVS_ADDRESS == `PIE_OFS_EN_B);
    assign wr_c = AVS_WRITE && (state == PIE_ACK) && lane0 && (AVS_ADDRESS == `PIE_OFS_EN_C);
    assign wr_ctrl = AVS_WRITE && (state == PIE_ACK) && lane0 && (AVS_ADDRESS == `PIE_OFS_CTRL);
    assign wr_mask = AVS_WRITE && (state == PIE_ACK) && lane0 && (AVS_ADDRESS == `PIE_OFS_MASK);
    // cleared as its data is captured, so no event slips between
    assign rd_stat = AVS_READ && take && (AVS_ADDRESS == `PIE_OFS_STAT);

    // next state: one wait cycle, then a one-cycle answer
    always_comb begin
        case (state)
            PIE_IDLE: begin
                next_state = req ? PIE_ACK : PIE_IDLE;
            end
            PIE_ACK: begin
                next_state = PIE_IDLE;
            end
            default: begin
                next_state = PIE_IDLE;
            end
        endcase
    end

    // state, waitrequest and read data registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= PIE_IDLE;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0;
        end else begin
            state <= next_state;
            AVS_WAITREQUEST <= !take;
            if (take && AVS_READ) begin
                AVS_READDATA <= rd_mux;
            end
        end
    end

    // =========================================================
    // enable and control registers
    // =========================================================
    // stored enables
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] en_c;
    // control: global enable and priority scheme
    logic [1:0] ctrl;
    // status mask
    logic [`PIE_ST_WIDTH-1:0] st_mask;
    // implemented bits of the second register
    localparam logic [7:0] IMPL_B = ~(8'h01 << `PIE_B_UNIMPL_BIT)
        & ~(LARGE_PACKAGE ? 8'h00 : ((8'h01 << `PIE_B_CMP_BIT) | (8'h01 << `PIE_B_ECC_BIT)));

    // each register but the second stores all that software writes
    pie_enable_reg #(.WIDTH(8), .IMPL(8'hff), .RESET(`PIE_EN_RESET)) u_en_a (
        .clk(CLK),
        .rst(RST),
        .wr_en(wr_a),
        .wr_data(AVS_WRITEDATA[7:0]),
        .value(en_a)
    );

    // bit 5 never stores, reads zero
    // comparator and enhanced capture bits need large package
    pie_enable_reg #(.WIDTH(8), .IMPL(IMPL_B), .RESET(`PIE_EN_RESET)) u_en_b (
        .clk(CLK),
        .rst(RST),
        .wr_en(wr_b),
        .wr_data(AVS_WRITEDATA[7:0]),
        .value(en_b)
    );

    // can enables, stored whole; the mode masks them below
    pie_enable_reg #(.WIDTH(8), .IMPL(8'hff), .RESET(`PIE_EN_RESET)) u_en_c (
        .clk(CLK),
        .rst(RST),
        .wr_en(wr_c),
        .wr_data(AVS_WRITEDATA[7:0]),
        .value(en_c)
    );

    // control register
    pie_enable_reg #(.WIDTH(2), .IMPL(2'h3), .RESET(`PIE_CTRL_RESET)) u_ctrl (
        .clk(CLK),
        .rst(RST),
        .wr_en(wr_ctrl),
        .wr_data(AVS_WRITEDATA[1:0]),
        .value(ctrl)
    );

    // status mask register
    pie_enable_reg #(.WIDTH(`PIE_ST_WIDTH), .IMPL(3'h7), .RESET(`PIE_ST_RESET)) u_mask (
        .clk(CLK),
        .rst(RST),
        .wr_en(wr_mask),
        .wr_data(AVS_WRITEDATA[`PIE_ST_WIDTH-1:0]),
        .value(st_mask)
    );

    // =========================================================
    // can mode masking
    // =========================================================
    // mode 0 uses all bits as stored
    logic mode_zero;
    // mode 1: bit 0 has no meaning
    logic mode_one;
    // bits that exist in the current mode
    logic [7:0] can_keep;
    // effective can enables
    logic [7:0] can_eff;

    assign mode_zero = (CAN_MODE == PIE_CAN_MODE0);
    assign mode_one = (CAN_MODE == PIE_CAN_MODE1);
    // buffer 1 and 0 enables forced low outside mode 0
    // bit 0 unimplemented in mode 1
    // stored bits are kept so a return to mode 0 restores them
    assign can_keep = ~((mode_zero ? 8'h00 : (8'h01 << `PIE_C_TXB1_BIT))
        | (mode_zero ? 8'h00 : (8'h01 << `PIE_C_TXB0_BIT))
        | (mode_one ? (8'h01 << `PIE_C_RXB0_BIT) : 8'h00));
    assign can_eff = en_c & can_keep;

    // =========================================================
    // gating and request forming
    // =========================================================
    // unit flags passed by their enables
    logic [7:0] act_a;
    logic [7:0] act_b;
    logic [7:0] act_c;
    // global enable and priority scheme
    logic gpe;
    logic prio_on;
    // any enabled source
    logic any_act;
    // any enabled high or low priority source
    logic any_high;
    logic any_low;
    // next values of the request outputs
    logic next_periph;
    logic next_high;
    logic next_low;
    assign gpe = ctrl[`PIE_CTRL_GLOBAL_BIT];
    assign prio_on = ctrl[`PIE_CTRL_PRIO_BIT];
    // bits 6..3 gate converter and serial sources
    // bits 2..0 gate capture and timer sources
    assign act_a = FLAGS_A & en_a;
    // bits 7,6,4,3 gate oscillator to collision
    // bits 2..0 gate voltage, timer, capture
    assign act_b = FLAGS_B & en_b;
    // top three bits gate in every mode
    // bit 4 gates one or all tx buffers
    // bit 1 gates one or all rx buffers
    assign act_c = FLAGS_C & can_eff;
    // or over all flag and enable pairs
    assign any_act = |{act_a, act_b, act_c};
    // priority bits only split requests with the scheme on
    assign any_high = |({act_a, act_b, act_c} & {PRIO_A, PRIO_B, PRIO_C});
    assign any_low = |({act_a, act_b, act_c} & ~{PRIO_A, PRIO_B, PRIO_C});
    assign next_high = prio_on && any_high;
    assign next_low = prio_on && any_low;
    // single-level scheme needs the global enable
    assign next_periph = !prio_on && gpe && any_act;

    // registered requests toward the core
    always_ff @(posedge CLK) begin
        if (RST) begin
            PERIPH_REQ <= 1'b0;
            HIGH_REQ <= 1'b0;
            LOW_REQ <= 1'b0;
        end else begin
            PERIPH_REQ <= next_periph;
            HIGH_REQ <= next_high;
            LOW_REQ <= next_low;
        end
    end

    // =========================================================
    // event status and bank interrupt
    // =========================================================
    // rising edge of each request output
    logic [`PIE_ST_WIDTH-1:0] ev;
    // sticky status
    logic [`PIE_ST_WIDTH-1:0] status;
    assign ev[`PIE_ST_PERIPH_BIT] = next_periph && !PERIPH_REQ;
    assign ev[`PIE_ST_HIGH_BIT] = next_high && !HIGH_REQ;
    assign ev[`PIE_ST_LOW_BIT] = next_low && !LOW_REQ;
    // sticky bits, read clears, new event wins
    pie_status #(.WIDTH(`PIE_ST_WIDTH)) u_status (
        .clk(CLK),
        .rst(RST),
        .set(ev),
        .clr(rd_stat),
        .status(status)
    );

    // level output while an unmasked bit is set
    always_ff @(posedge CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status & st_mask);
        end
    end

    // =========================================================
    // read data selection
    // =========================================================
    // unmapped offsets read zero, writes to them are dropped
    assign rd_mux = (AVS_ADDRESS == `PIE_OFS_EN_A) ? {24'h0, en_a} :
        (AVS_ADDRESS == `PIE_OFS_EN_B) ? {24'h0, en_b} :
        (AVS_ADDRESS == `PIE_OFS_EN_C) ? {24'h0, can_eff} :
        (AVS_ADDRESS == `PIE_OFS_CTRL) ? {30'h0, ctrl} :
        (AVS_ADDRESS == `PIE_OFS_STAT) ? {29'h0, status} :
        (AVS_ADDRESS == `PIE_OFS_MASK) ? {29'h0, st_mask} : 32'h0;

    // =========================================================
    // checks
    // =========================================================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    chk_write_stores: assert property (
        wr_a |=> en_a == $past(AVS_WRITEDATA[7:0]))
        else $error("enable register did not take written value");
    chk_unimpl_read: assert property (
        (take && AVS_READ && AVS_ADDRESS == `PIE_OFS_EN_B) |=> !AVS_READDATA[5])
        else $error("unimplemented bit read as one");
    chk_small_package: assert property (
        !LARGE_PACKAGE |-> (!en_b[6] && !en_b[0]))
        else $error("large package bit set on small package");
    chk_can_forced: assert property (
        !mode_zero |-> can_eff[3:2] == 2'h0)
        else $error("buffer enables not forced low");
    chk_can_bit0: assert property (
        mode_one |-> !can_eff[0])
        else $error("bit 0 active in mode 1");
    chk_no_priority: assert property (
        !prio_on |=> (!HIGH_REQ && !LOW_REQ))
        else $error("priority request without priority scheme");
    chk_global_gate: assert property (
        (!prio_on && !gpe) |=> !PERIPH_REQ)
        else $error("request passed without global enable");
    chk_or_request: assert property (
        (!prio_on && gpe && |(FLAGS_C & can_eff)) |=> PERIPH_REQ)
        else $error("enabled flag did not raise request");
    chk_gate_first: assert property (
        (!prio_on && gpe && FLAGS_A == 8'h40 && !en_a[6] && !(|act_b) && !(|act_c))
        |=> !PERIPH_REQ)
        else $error("disabled converter flag raised request");
    chk_bus_answer: assert property (
        take |=> (!AVS_WAITREQUEST ##1 AVS_WAITREQUEST))
        else $error("bus answer not one cycle after request");
endmodule

// file: tb/pie_far_side.sv
// far-side model: peripheral flag sources, priority levels and can mode
`timescale 1ns/1ns
module pie_far_side (
    // clock
    input wire logic clk,
    // flag levels toward the bank
    output logic [7:0] flags_a,
    output logic [7:0] flags_b,
    output logic [7:0] flags_c,
    // priority level per source and can operating mode
    output logic [7:0] prio,
    output pie_pkg::pie_can_mode_type can_mode
);
    import pie_pkg::*;
    // ==========================================================
    // quiet sources at time zero
    initial begin
        flags_a = 8'h00;
        flags_b = 8'h00;
        flags_c = 8'h00;
        prio = 8'h00;
        can_mode = PIE_CAN_MODE0;
    end
    // raise flags of one register only, the others go quiet
    task automatic drive(input int r, input logic [7:0] v);
        @(posedge clk);
        flags_a <= (r == 0) ? v : 8'h00;
        flags_b <= (r == 1) ? v : 8'h00;
        flags_c <= (r == 2) ? v : 8'h00;
    endtask
    // priority and mode change together, just after an edge
    task automatic levels(input logic [7:0] p, input pie_can_mode_type m);
        @(posedge clk);
        prio <= p;
        can_mode <= m;
    endtask
endmodule

// file: tb/pie_bank_tb.sv
// self-checking bench of the peripheral interrupt enable bank
`timescale 1ns/1ns
`include "pie_map.svh"
module pie_bank_tb;
    import pie_pkg::*;
    // ==========================================================
    // bench signals
    logic clk, rst, avs_read, avs_write, periph_req, high_req, low_req, irq, wait_l;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, rd_l, rd_s, rdata, rdata_s;
    logic [3:0] avs_byteenable;
    logic [7:0] flags_a, flags_b, flags_c, prio;
    pie_can_mode_type can_mode;
    int fail_count = 0;
    int checked = 0;
    // offsets of the three enable registers
    logic [5:0] offs [3] = '{`PIE_OFS_EN_A, `PIE_OFS_EN_B, `PIE_OFS_EN_C};
    // can enable readback per mode after writing all ones
    logic [7:0] can_read [3] = '{8'hff, 8'hf2, 8'hf3};
    // ==========================================================
    // design, large package, and a small one read back only
    pie_bank u_pie_bank (.CLK(clk), .RST(rst), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(rd_l), .AVS_WAITREQUEST(wait_l),
        .FLAGS_A(flags_a), .FLAGS_B(flags_b), .FLAGS_C(flags_c), .PRIO_A(prio),
        .PRIO_B(prio), .PRIO_C(prio), .CAN_MODE(can_mode), .PERIPH_REQ(periph_req),
        .HIGH_REQ(high_req), .LOW_REQ(low_req), .IRQ(irq));
    // software never writes the first register on the small package
    pie_bank #(.LARGE_PACKAGE(1'b0)) u_pie_bank_small (.CLK(clk), .RST(rst),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write && (avs_address != `PIE_OFS_EN_A)),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(rd_s), .AVS_WAITREQUEST(), .FLAGS_A(flags_a), .FLAGS_B(flags_b),
        .FLAGS_C(flags_c), .PRIO_A(prio), .PRIO_B(prio), .PRIO_C(prio),
        .CAN_MODE(can_mode), .PERIPH_REQ(), .HIGH_REQ(), .LOW_REQ(), .IRQ());
    pie_far_side u_pie_far_side (.clk(clk), .flags_a(flags_a), .flags_b(flags_b),
        .flags_c(flags_c), .prio(prio), .can_mode(can_mode));
    // free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========================================================
    // verdict, the single exit of the run
    task automatic complete_run();
        $display("fail_count %0d checked %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // compare with case equality so unknowns never match
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (wait_l !== 1'b0 && n < 20);
        rdata = rd_l;
        rdata_s = rd_s;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // a slave that never answers ends the run
        if (n >= 20) begin
            fail_count++;
            $display("CHECK FAILED at %0t: bus wait ran out", $time);
            complete_run();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'hf);
        chk(rdata, {24'h000000, e}, "register read");
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask
    // ==========================================================
    // everything reads zero after reset, unmapped place too
    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            rd(6'(4 * i), 8'h00);
        end
        rd(6'h18, 8'h00);
    endtask
    // each implemented enable bit alone passes its source, its absence blocks it
    task automatic t_gate();
        wr(`PIE_OFS_CTRL, 8'h01);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 8; i++) begin
                if (r == 1 && i == 5) continue;
                wr(offs[r], 8'h01 << i);
                u_pie_far_side.drive(r, 8'hff);
                pause(3);
                chk(periph_req, 1'b1, "enabled source blocked");
                wr(offs[r], ~(8'h01 << i));
                u_pie_far_side.drive(r, 8'h01 << i);
                pause(3);
                chk(periph_req, 1'b0, "disabled source passed");
            end
            wr(offs[r], 8'h00);
        end
    endtask
    // unimplemented and large-only bits of the second register
    task automatic t_regb();
        wr(`PIE_OFS_EN_B, 8'hff);
        rd(`PIE_OFS_EN_B, 8'hdf);
        chk(rdata_s, 32'h0000009e, "small package readback");
        wr(`PIE_OFS_EN_B, 8'h00);
    endtask
    // mode dependent can bits, readback and gating
    task automatic t_can();
        wr(`PIE_OFS_EN_C, 8'hff);
        for (int m = 0; m < 3; m++) begin
            u_pie_far_side.levels(8'h00, pie_can_mode_type'(m));
            rd(`PIE_OFS_EN_C, can_read[m]);
        end
        wr(`PIE_OFS_EN_C, 8'h0d);
        u_pie_far_side.drive(2, 8'h0d);
        for (int m = 0; m < 3; m++) begin
            u_pie_far_side.levels(8'h00, pie_can_mode_type'(m));
            pause(3);
            chk(periph_req, m != 1, "can mode gating");
        end
        u_pie_far_side.drive(2, 8'h0c);
        pause(3);
        chk(periph_req, 1'b0, "forced tx bits passed");
        u_pie_far_side.levels(8'h00, PIE_CAN_MODE0);
        wr(`PIE_OFS_EN_C, 8'h00);
    endtask
    // global enable needed without priorities, priority split with them
    task automatic t_prio();
        wr(`PIE_OFS_CTRL, 8'h00);
        wr(`PIE_OFS_EN_A, 8'h01);
        u_pie_far_side.drive(0, 8'h01);
        pause(3);
        chk(periph_req, 1'b0, "global enable ignored");
        wr(`PIE_OFS_CTRL, 8'h02);
        u_pie_far_side.levels(8'h01, PIE_CAN_MODE0);
        pause(3);
        chk({periph_req, high_req, low_req}, 3'b010, "high priority route");
        u_pie_far_side.levels(8'h00, PIE_CAN_MODE0);
        pause(3);
        chk({periph_req, high_req, low_req}, 3'b001, "low priority route");
        wr(`PIE_OFS_CTRL, 8'h01);
        pause(3);
        chk({periph_req, high_req, low_req}, 3'b100, "priority selection kept");
        rd(`PIE_OFS_STAT, 8'h07);
    endtask
    // sticky status, mask and the bank interrupt
    task automatic t_irq();
        u_pie_far_side.drive(0, 8'h00);
        pause(3);
        bus(1'b0, `PIE_OFS_STAT, 8'h00, 4'hf);
        wr(`PIE_OFS_MASK, 8'h01);
        u_pie_far_side.drive(0, 8'h01);
        pause(4);
        chk(irq, 1'b1, "unmasked event silent");
        rd(`PIE_OFS_STAT, 8'h01);
        pause(3);
        chk(irq, 1'b0, "interrupt after clear");
        wr(`PIE_OFS_MASK, 8'h00);
        u_pie_far_side.drive(0, 8'h00);
        pause(3);
        u_pie_far_side.drive(0, 8'h01);
        pause(4);
        chk(irq, 1'b0, "masked event raised");
        rd(`PIE_OFS_STAT, 8'h01);
    endtask
    // refused writes: lane zero off, unmapped place
    task automatic t_refused();
        wr(`PIE_OFS_EN_A, 8'h3c);
        bus(1'b1, `PIE_OFS_EN_A, 8'hc3, 4'he);
        rd(`PIE_OFS_EN_A, 8'h3c);
        bus(1'b1, 6'h18, 8'hff, 4'hf);
        rd(6'h18, 8'h00);
        wr(`PIE_OFS_EN_A, 8'h00);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_gate();
        t_regb();
        t_can();
        t_prio();
        t_irq();
        t_refused();
        complete_run();
    end
endmodule
